/* hw/bdoc_top.sv */
`timescale 1ns/1ps
`include "bdoc_cfg.svh"

// Function
// - With offset compensation on, flip offset polarity every buck period.
// - Count switch-overcurrent periods up to the 3-bit limit plus one.
// - Clear both counters when channel disabled and at each dimming cycle.
// - At switch target, hold the buck off until the flag is read.
// - Reading the channel flag re-enables the locked channel.
// - Count sense-overvoltage periods up to the 7-bit limit plus one.
// - Per channel select bit: 1 external dimming, 0 internal dimming.
// - External mode follows the control input delayed by about 4 us.
// - Rising and falling edges get the same fixed delay.
// - External mode copies the input waveform, clock sampling aside.
// - Internal duty 1000 to 1023 gives full on-time.
// - Each duty step is one thousandth of the dimming period.
// - Shared 2-bit frequency: 500, 1000, 2000 or 4000 Hz.

module bdoc_top #(
   parameter int DW = 16,
   parameter int SW_W = 3,
   parameter int SE_W = 7
)(
   input wire logic i_core_clk,          // Core clock, 250 MHz
   input wire logic i_nrst,              // Async reset, active low
   input wire logic [4:0] i_addr,        // Register byte address
   input wire logic [DW-1:0] i_wdata,    // Write data
   input wire logic i_wr,                // Write strobe
   input wire logic i_rd,                // Read strobe
   output logic [DW-1:0] o_rdata,        // Read data, cycle after strobe
   input wire logic [1:0] i_buck_period, // Buck period start pulse
   input wire logic [1:0] i_sw_oc,       // Switch current over limit
   input wire logic [1:0] i_sense_oc,    // Sense voltage over threshold
   input wire logic [1:0] i_dim_ctrl,    // External dimming inputs
   output logic [1:0] o_buck_on,         // Buck channel run
   output logic [1:0] o_offset_pol,      // Peak offset polarity
   output logic o_irq                    // Interrupt, active high
);
   localparam int CLK_MHZ = `BDOC_CLK_HZ / 1000000;
   // Longest-time style rounding down, one cycle used by the output flop
   localparam int DLY = (`BDOC_PHASE_NS * CLK_MHZ) / 1000;
   localparam int BASE_I = `BDOC_CLK_HZ /
                           (`BDOC_DIM_BASE_HZ * `BDOC_DIM_STEPS);
   localparam logic [9:0] BASE = 10'(BASE_I);
   localparam logic [9:0] LAST = 10'(`BDOC_DIM_STEPS - 1);
   localparam logic [9:0] FULL = 10'(`BDOC_DUTY_FULL);

   if (DW < `BDOC_LIM_W || SW_W > 8 || SE_W > 7 || DLY < 2 ||
       BASE_I < 8 || BASE_I > 1023)
   begin : g_bad
      $error("bdoc_top: bad parameter");
   end

   logic [`BDOC_CTRL_W-1:0] ctrl_reg, ctrl_next;
   logic [`BDOC_DUTY_W-1:0] duty_reg [2];
   logic [`BDOC_DUTY_W-1:0] duty_next [2];
   logic [`BDOC_LIM_W-1:0] lim_reg [2];
   logic [`BDOC_LIM_W-1:0] lim_next [2];
   logic [1:0] flag_reg, flag_next, ist_reg, ist_next, imask_reg, imask_next;
   logic [DW-1:0] rdata_reg, rdata_next;
   logic irq_reg, irq_next;
   logic [9:0] acc_reg, acc_next, acc_sum, step, thou_reg, thou_next;
   logic tick, int_cyc, flag_rd;
   logic [1:0] hit, lock, buck_on, ofs_pol, int_on;
   bdoc_pkg::bdoc_freq_t freq;

   ////////////////////////////////////////////////////////////////////////
   // Shared dimming divider: fractional accumulator keeps 4 kHz exact on
   // average at the cost of one cycle of jitter per thousandth tick
   always_comb
   begin
      freq = bdoc_pkg::bdoc_freq_t'(ctrl_reg[`BDOC_CTRL_FRQ +: 2]);
      step = 10'h001 << freq;
      acc_sum = acc_reg + step;
      tick = acc_sum >= BASE;
      acc_next = tick ? acc_sum - BASE : acc_sum;
      int_cyc = tick && (thou_reg == LAST);
      thou_next = thou_reg;
      if (tick)
      begin
         thou_next = (thou_reg == LAST) ? 10'h000 : thou_reg + 10'h001;
      end
      for (int i = 0; i < 2; i++)
      begin
         // Saturates at full value, one step per thousandth
         int_on[i] = (duty_reg[i] >= FULL) ||
                     (thou_reg < duty_reg[i]);
      end
   end

   always_ff @(posedge i_core_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         acc_reg <= 10'h000;
         thou_reg <= 10'h000;
      end
      else
      begin
         acc_reg <= acc_next;
         thou_reg <= thou_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register file
   always_comb
   begin
      ctrl_next = ctrl_reg;
      duty_next = duty_reg;
      lim_next = lim_reg;
      imask_next = imask_reg;
      flag_rd = i_rd && (i_addr == `BDOC_A_STAT);
      // Hardware set wins over read-clear and write-one-clear
      flag_next = hit | (flag_reg & ~{2{flag_rd}});
      ist_next = ist_reg;
      if (i_wr)
      begin
         case (i_addr)
            `BDOC_A_CTRL: ctrl_next = i_wdata[`BDOC_CTRL_W-1:0];
            `BDOC_A_DUTY1: duty_next[0] = i_wdata[`BDOC_DUTY_W-1:0];
            `BDOC_A_DUTY2: duty_next[1] = i_wdata[`BDOC_DUTY_W-1:0];
            `BDOC_A_LIM1: lim_next[0] = i_wdata[`BDOC_LIM_W-1:0];
            `BDOC_A_LIM2: lim_next[1] = i_wdata[`BDOC_LIM_W-1:0];
            `BDOC_A_ISTAT: ist_next = ist_reg & ~i_wdata[1:0];
            `BDOC_A_IMASK: imask_next = i_wdata[1:0];
            default: ;
         endcase
      end
      ist_next = ist_next | hit;
      irq_next = |(ist_reg & imask_reg);
      rdata_next = '0;
      if (i_rd)
      begin
         case (i_addr)
            `BDOC_A_CTRL: rdata_next = DW'(ctrl_reg);
            `BDOC_A_DUTY1: rdata_next = DW'(duty_reg[0]);
            `BDOC_A_DUTY2: rdata_next = DW'(duty_reg[1]);
            `BDOC_A_LIM1: rdata_next = DW'(lim_reg[0]);
            `BDOC_A_LIM2: rdata_next = DW'(lim_reg[1]);
            `BDOC_A_STAT: rdata_next = DW'({buck_on, lock, flag_reg});
            `BDOC_A_ISTAT: rdata_next = DW'(ist_reg);
            `BDOC_A_IMASK: rdata_next = DW'(imask_reg);
            default: rdata_next = '0;
         endcase
      end
   end

   always_ff @(posedge i_core_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         ctrl_reg <= `BDOC_CTRL_RST;
         duty_reg[0] <= `BDOC_DUTY_RST;
         duty_reg[1] <= `BDOC_DUTY_RST;
         lim_reg[0] <= `BDOC_LIM_RST;
         lim_reg[1] <= `BDOC_LIM_RST;
         flag_reg <= 2'h0;
         ist_reg <= 2'h0;
         imask_reg <= 2'h0;
         rdata_reg <= '0;
         irq_reg <= 1'b0;
      end
      else
      begin
         ctrl_reg <= ctrl_next;
         duty_reg <= duty_next;
         lim_reg <= lim_next;
         flag_reg <= flag_next;
         ist_reg <= ist_next;
         imask_reg <= imask_next;
         rdata_reg <= rdata_next;
         irq_reg <= irq_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Channels
   for (genvar i = 0; i < 2; i++)
   begin : g_ch
      bdoc_chan_if #(.SW_W(SW_W), .SE_W(SE_W)) u_if ();

      assign u_if.enable = ctrl_reg[`BDOC_CTRL_EN + i];
      assign u_if.ofs_en = ctrl_reg[`BDOC_CTRL_OFS + i];
      assign u_if.src = bdoc_pkg::bdoc_dim_source_select_t'(
                           ctrl_reg[`BDOC_CTRL_SRC + i]);
      assign u_if.sw_lim = lim_reg[i][`BDOC_LIM_SW +: SW_W];
      assign u_if.se_lim = lim_reg[i][`BDOC_LIM_SE +: SE_W];
      assign u_if.int_on = int_on[i];
      assign u_if.int_cyc = int_cyc;
      assign u_if.period = i_buck_period[i];
      assign u_if.sw_oc = i_sw_oc[i];
      assign u_if.se_oc = i_sense_oc[i];
      assign u_if.ctrl_in = i_dim_ctrl[i];
      assign u_if.flag_rd = flag_rd;
      assign hit[i] = u_if.hit;
      assign lock[i] = u_if.lock;
      assign buck_on[i] = u_if.buck_on;
      assign ofs_pol[i] = u_if.ofs_pol;

      bdoc_chan #(
         .SW_W(SW_W),
         .SE_W(SE_W),
         .DEPTH(DLY - 1)
      ) u_chan (
         .i_core_clk(i_core_clk),
         .i_nrst(i_nrst),
         .ch(u_if.chan)
      );
   end

   assign o_rdata = rdata_reg;
   assign o_buck_on = buck_on;
   assign o_offset_pol = ofs_pol;
   assign o_irq = irq_reg;

   ////////////////////////////////////////////////////////////////////////
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_nrst);

   duty_full_a: assert property (
      duty_reg[0] >= FULL |-> int_on[0])
      else $error("full duty not always on");
   period_wrap_a: assert property (
      int_cyc |=> thou_reg == 10'h000)
      else $error("dimming period did not wrap to zero");
   step_rate_a: assert property (
      tick |=> !tick)
      else $error("thousandth ticks back to back");
   flag_set_a: assert property (
      hit[0] |=> flag_reg[0] && ist_reg[0])
      else $error("hit did not set flag");
   irq_level_a: assert property (
      |(ist_reg & imask_reg) |=> o_irq)
      else $error("masked status did not raise irq");

   cyc_c: cover property (int_cyc);
   irq_c: cover property (o_irq ##[1:20] !o_irq);
endmodule

/* pkg/bdoc_cfg.svh */
`ifndef BDOC_CFG_SVH
`define BDOC_CFG_SVH

// Register byte addresses
`define BDOC_A_CTRL 5'h00
`define BDOC_A_DUTY1 5'h04
`define BDOC_A_DUTY2 5'h08
`define BDOC_A_LIM1 5'h0C
`define BDOC_A_LIM2 5'h10
`define BDOC_A_STAT 5'h14
`define BDOC_A_ISTAT 5'h18
`define BDOC_A_IMASK 5'h1C

// Control register layout, channel index added to the EN, OFS and SRC base bits; FRQ is one shared 2-bit field
`define BDOC_CTRL_W 8
`define BDOC_CTRL_EN 0
`define BDOC_CTRL_OFS 2
`define BDOC_CTRL_SRC 4
`define BDOC_CTRL_FRQ 6
`define BDOC_CTRL_RST 8'h00

// Limit register layout
`define BDOC_LIM_W 16
`define BDOC_LIM_SW 0
`define BDOC_LIM_SE 8
`define BDOC_LIM_RST 16'h7F07

// Status register layout
`define BDOC_STAT_FLAG 0
`define BDOC_STAT_LOCK 2
`define BDOC_STAT_ON 4

// Duty and dimming
`define BDOC_DUTY_W 10
`define BDOC_DUTY_RST 10'h000
`define BDOC_DUTY_FULL 1000
`define BDOC_DIM_STEPS 1000
`define BDOC_DIM_BASE_HZ 500

// Timing
`define BDOC_CLK_HZ 250000000
`define BDOC_PHASE_NS 4000

`endif

/* pkg/bdoc_pkg.sv */
package bdoc_pkg;

   typedef enum logic
   {
      BDOC_DIM_INT = 1'b0,
      BDOC_DIM_EXT = 1'b1
   } bdoc_dim_source_select_t;

   typedef enum logic [1:0]
   {
      BDOC_F500 = 2'h0,
      BDOC_F1K = 2'h1,
      BDOC_F2K = 2'h2,
      BDOC_F4K = 2'h3
   } bdoc_freq_t;

endpackage

/* pkg/bdoc_chan_if.sv */
`timescale 1ns/1ps

interface bdoc_chan_if #(
   parameter int SW_W = 3,
   parameter int SE_W = 7
);
   logic enable;
   logic ofs_en;
   bdoc_pkg::bdoc_dim_source_select_t src;
   logic [SW_W-1:0] sw_lim;
   logic [SE_W-1:0] se_lim;
   logic int_on;
   logic int_cyc;
   logic period;
   logic sw_oc;
   logic se_oc;
   logic ctrl_in;
   logic flag_rd;
   logic buck_on;
   logic ofs_pol;
   logic hit;
   logic lock;

   modport ctl (
      output enable, ofs_en, src, sw_lim, se_lim, int_on, int_cyc,
      output period, sw_oc, se_oc, ctrl_in, flag_rd,
      input buck_on, ofs_pol, hit, lock
   );

   modport chan (
      input enable, ofs_en, src, sw_lim, se_lim, int_on, int_cyc,
      input period, sw_oc, se_oc, ctrl_in, flag_rd,
      output buck_on, ofs_pol, hit, lock
   );
endinterface

/* hw/bdoc_chan.sv */
`timescale 1ns/1ps

module bdoc_chan #(
   parameter int SW_W = 3,
   parameter int SE_W = 7,
   parameter int DEPTH = 999
)(
   input wire logic i_core_clk, // Core clock
   input wire logic i_nrst,     // Async reset, active low
   bdoc_chan_if.chan ch         // Channel controls and status
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [SW_W:0] sw_cnt_reg, sw_cnt_next, sw_tgt;
   logic [SE_W:0] se_cnt_reg, se_cnt_next, se_tgt;
   logic [PW-1:0] ptr_reg, ptr_next;
   logic line_reg [DEPTH];
   logic lock_reg, lock_next, pol_reg, pol_next;
   logic buck_reg, buck_next, prev_reg;
   logic ext_dly, cyc, clr, sw_step, se_step, hit, dim_on, is_ext;

   if (DEPTH < 1 || SW_W < 1 || SE_W < 1)
   begin : g_bad
      $error("bdoc_chan: bad parameter");
   end

   ////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      is_ext = (ch.src == bdoc_pkg::BDOC_DIM_EXT);
      ext_dly = line_reg[ptr_reg];
      // Dimming cycle starts on rising delayed edge or divider wrap
      cyc = is_ext ? (ext_dly && !prev_reg) : ch.int_cyc;
      // Release also restarts counting, else the count held at its target blocks any relock
      clr = !ch.enable || cyc || (lock_reg && ch.flag_rd);
      sw_tgt = {1'b0, ch.sw_lim} + 1'b1;
      se_tgt = {1'b0, ch.se_lim} + 1'b1;
      // Less-than, so a limit lowered mid-count cannot let it wrap
      sw_step = ch.period && ch.sw_oc && (sw_cnt_reg < sw_tgt);
      se_step = ch.period && ch.se_oc && (se_cnt_reg < se_tgt);
      sw_cnt_next = clr ? '0 : sw_cnt_reg + (SW_W+1)'(sw_step);
      se_cnt_next = clr ? '0 : se_cnt_reg + (SE_W+1)'(se_step);
      hit = !clr && ((sw_step && sw_cnt_next == sw_tgt) ||
                     (se_step && se_cnt_next == se_tgt));
      // Release read wins, as clr also masks hit in that cycle
      lock_next = hit || (lock_reg && !ch.flag_rd);
      pol_next = ch.ofs_en ? (pol_reg ^ ch.period) : 1'b0;
      dim_on = is_ext ? ext_dly : ch.int_on;
      buck_next = ch.enable && !lock_reg && dim_on;
      ptr_next = (ptr_reg == PW'(DEPTH - 1)) ? '0 : ptr_reg + 1'b1;
   end

   always_ff @(posedge i_core_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         sw_cnt_reg <= '0;
         se_cnt_reg <= '0;
         lock_reg <= 1'b0;
         pol_reg <= 1'b0;
         buck_reg <= 1'b0;
         prev_reg <= 1'b0;
         ptr_reg <= '0;
      end
      else
      begin
         sw_cnt_reg <= sw_cnt_next;
         se_cnt_reg <= se_cnt_next;
         lock_reg <= lock_next;
         pol_reg <= pol_next;
         buck_reg <= buck_next;
         prev_reg <= ext_dly;
         ptr_reg <= ptr_next;
      end
   end

   // Same line delays both edges alike, so duty is kept exactly
   always_ff @(posedge i_core_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         for (int k = 0; k < DEPTH; k++)
         begin
            line_reg[k] <= 1'b0;
         end
      end
      else
      begin
         line_reg[ptr_reg] <= ch.ctrl_in;
      end
   end

   assign ch.buck_on = buck_reg;
   assign ch.ofs_pol = pol_reg;
   assign ch.hit = hit;
   assign ch.lock = lock_reg;

   ////////////////////////////////////////////////////////////////////////
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_nrst);

   ofs_toggle_a: assert property (
      ch.ofs_en && ch.period |=> pol_reg != $past(pol_reg))
      else $error("offset polarity did not toggle");
   sw_cap_a: assert property (
      sw_cnt_reg >= sw_tgt |=> sw_cnt_reg <= $past(sw_cnt_reg))
      else $error("switch counter passed its target");
   cnt_clear_a: assert property (
      !ch.enable |=> sw_cnt_reg == '0 && se_cnt_reg == '0)
      else $error("counters not cleared while disabled");
   lock_off_a: assert property (lock_reg |=> !buck_reg)
      else $error("buck on while locked");
   lock_release_a: assert property (
      lock_reg && ch.flag_rd && !hit |=> !lock_reg)
      else $error("lock kept after flag read");
   se_cap_a: assert property (
      se_cnt_reg >= se_tgt |=> se_cnt_reg <= $past(se_cnt_reg))
      else $error("sense counter passed its target");
   se_lock_a: assert property (
      se_step && !clr && se_cnt_next == se_tgt |=> lock_reg)
      else $error("sense target reached without lock");
   ext_follow_a: assert property (
      is_ext && ch.enable && !lock_reg |=> buck_reg == $past(ext_dly))
      else $error("buck does not follow delayed input");

   lock_hit_c: cover property (hit ##[1:50] ch.flag_rd && lock_reg);
   ext_edge_c: cover property (is_ext && ext_dly && !prev_reg);
   sw_lock_c: cover property (sw_step && sw_cnt_next == sw_tgt);
endmodule

/* bench/bdoc_buck_model.sv */
`timescale 1ns/1ps

module bdoc_buck_model #(
   parameter int PER = 8
)(
   input wire logic i_core_clk,      // Core clock
   input wire logic i_nrst,          // Async reset, active low
   input wire logic [1:0] i_sw_bad,  // Commanded switch fault
   input wire logic [1:0] i_se_bad,  // Commanded sense fault
   input wire logic [1:0] i_dim_lvl, // Wanted dimming level
   input wire logic [1:0] i_buck_on, // Buck run from device
   output logic [1:0] o_period,      // Period start pulses
   output logic [1:0] o_sw_oc,       // Switch comparator
   output logic [1:0] o_se_oc,       // Sense comparator
   output logic [1:0] o_dim_ctrl     // Dimming source level
);
   logic [7:0] cnt_reg;
   logic [7:0] cnt_next;

   always_comb
   begin
      cnt_next = (cnt_reg == 8'(PER - 1)) ? 8'h00 : cnt_reg + 8'h01;
   end

   always_ff @(posedge i_core_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         cnt_reg <= 8'h00;
      else
         cnt_reg <= cnt_next;
   end

   // Channels switch half a period apart
   assign o_period = {cnt_reg == 8'h04, cnt_reg == 8'h00};
   // A stopped switch cannot trip its comparators
   assign o_sw_oc = i_sw_bad & i_buck_on;
   assign o_se_oc = i_se_bad & i_buck_on;
   assign o_dim_ctrl = i_dim_lvl;
endmodule

/* bench/testbench.sv */
`timescale 1ns/1ps
`include "bdoc_cfg.svh"

module testbench;
   logic clk, nrst, wr, rd, irq, p;
   logic [4:0] addr;
   logic [15:0] wdata, rdata, rv;
   logic [1:0] per, swoc, seoc, dim, on, pol, swb, seb, lvl;
   int n_errors, compares, k, m;

   bdoc_top DUT (.i_core_clk(clk), .i_nrst(nrst), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
      .i_buck_period(per), .i_sw_oc(swoc), .i_sense_oc(seoc),
      .i_dim_ctrl(dim), .o_buck_on(on), .o_offset_pol(pol), .o_irq(irq));
   bdoc_buck_model PM (.i_core_clk(clk), .i_nrst(nrst), .i_sw_bad(swb),
      .i_se_bad(seb), .i_dim_lvl(lvl), .i_buck_on(on), .o_period(per),
      .o_sw_oc(swoc), .o_se_oc(seoc), .o_dim_ctrl(dim));

   ////////////////////////////////////////
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [4:0] a, input logic [15:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      rv = rdata;
      chk(rv, e);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic pulses(input int n);
      repeat (n) @(posedge clk iff per[0]);
      cyc(3);
   endtask

   task automatic wait_lvl(input logic v);
      for (k = 0; k < 70000 && on[0] !== v; k++)
         cyc(1);
   endtask

   task automatic stop_test;
      if (n_errors == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   ////////////////////////////////////////
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Clean run takes about 82k cycles, so a hang is caught at 100k
   initial
   begin
      #400000;
      n_errors++;
      stop_test();
   end

   initial
   begin
      nrst = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 5'h00;
      wdata = 16'h0000;
      swb = 2'h0;
      seb = 2'h0;
      lvl = 2'h0;
      n_errors = 0;
      compares = 0;
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      rd_chk(`BDOC_A_CTRL, 16'h0000);
      rd_chk(`BDOC_A_LIM1, 16'h7F07);
      rd_chk(`BDOC_A_STAT, 16'h0000);
      rd_chk(5'h02, 16'h0000);
      for (m = 0; m < 4; m++)
      begin
         wr_reg(`BDOC_A_CTRL, 16'(m * 80));
         rd_chk(`BDOC_A_CTRL, 16'(m * 80));
      end
      // Offset polarity flips per buck period
      wr_reg(`BDOC_A_DUTY1, 16'h03E8);
      wr_reg(`BDOC_A_CTRL, 16'h0005);
      pulses(1);
      p = pol[0];
      pulses(1);
      chk(pol[0], 16'(!p));
      pulses(1);
      chk(pol[0], p);
      chk(pol[1], 1'b0);
      chk(on[0], 1'b1);
      // Switch fault, counter cleared by disable in between
      wr_reg(`BDOC_A_LIM1, 16'h7F02);
      wr_reg(`BDOC_A_IMASK, 16'h0001);
      @(posedge clk);
      swb <= 2'h1;
      pulses(2);
      @(posedge clk);
      swb <= 2'h0;
      wr_reg(`BDOC_A_CTRL, 16'h0004);
      cyc(8);
      wr_reg(`BDOC_A_CTRL, 16'h0005);
      cyc(2);
      @(posedge clk);
      swb <= 2'h1;
      pulses(2);
      chk(on[0], 1'b1);
      pulses(1);
      chk(on[0], 1'b0);
      chk(irq, 1'b1);
      @(posedge clk);
      swb <= 2'h0;
      cyc(20);
      chk(on[0], 1'b0);
      rd_chk(`BDOC_A_STAT, 16'h0005);
      cyc(3);
      chk(on[0], 1'b1);
      rd_chk(`BDOC_A_STAT, 16'h0010);
      chk(irq, 1'b1);
      wr_reg(`BDOC_A_ISTAT, 16'h0001);
      cyc(2);
      chk(irq, 1'b0);
      // Sense fault with the interrupt masked
      wr_reg(`BDOC_A_LIM1, 16'h0107);
      wr_reg(`BDOC_A_IMASK, 16'h0000);
      @(posedge clk);
      seb <= 2'h1;
      pulses(1);
      chk(on[0], 1'b1);
      pulses(1);
      chk(on[0], 1'b0);
      chk(irq, 1'b0);
      rd_chk(`BDOC_A_ISTAT, 16'h0001);
      @(posedge clk);
      seb <= 2'h0;
      rd_chk(`BDOC_A_STAT, 16'h0005);
      wr_reg(`BDOC_A_ISTAT, 16'h0001);
      rd_chk(`BDOC_A_ISTAT, 16'h0000);
      // Quarter duty at 4 kHz: 250 steps of 62.5 cycles
      wr_reg(`BDOC_A_DUTY1, 16'h00FA);
      wr_reg(`BDOC_A_CTRL, 16'h00C1);
      wait_lvl(1'b0);
      wait_lvl(1'b1);
      for (m = 0; m < 70000 && on[0] === 1'b1; m++)
         cyc(1);
      chk(16'(m > 15560 && m < 15690), 16'h0001);
      wr_reg(`BDOC_A_DUTY1, 16'h03FF);
      cyc(1000);
      chk(on[0], 1'b1);
      wr_reg(`BDOC_A_DUTY1, 16'h0000);
      cyc(100);
      chk(on[0], 1'b0);
      // External dimming on channel 2 only
      wr_reg(`BDOC_A_CTRL, 16'h0022);
      cyc(5);
      @(posedge clk);
      lvl <= 2'h2;
      cyc(990);
      chk(on[1], 1'b0);
      cyc(20);
      chk(on[1], 1'b1);
      @(posedge clk);
      lvl <= 2'h0;
      cyc(990);
      chk(on[1], 1'b1);
      cyc(20);
      chk(on[1], 1'b0);
      // A three-cycle pulse must come through whole
      @(posedge clk);
      lvl <= 2'h2;
      repeat (3) @(posedge clk);
      lvl <= 2'h0;
      m = 0;
      repeat (1100)
      begin
         cyc(1);
         if (on[1] === 1'b1)
            m++;
      end
      chk(16'(m), 16'h0003);
      stop_test();
   end
endmodule
